//--- rotate_params.svh
// constants for the rotate-left-no-carry executor
`ifndef ROTATE_PARAMS_SVH
`define ROTATE_PARAMS_SVH
`define OPC_HI_POS 15
`define OPC_LO_POS 10
`define OPC_WIDTH 6
`define OPC_RLNC 6'h11
`define DEST_POS 9
`define ACC_POS 8
`define INDEX_LIMIT 8'h5F
`define ACCESS_SPLIT 8'h80
`define ACCESS_HI_BANK 4'hF
`define ACCESS_LO_BANK 4'h0
`define RESET_WREG 8'h00
`define RESET_BYTE 8'h00
`define RESET_ADDR 12'h000
`endif

//--- rotate_pkg.sv
// types shared by the rotate-left-no-carry executor
package rotate_pkg;
	typedef enum logic [1:0] {
		MODE_ACCESS = 2'h0,
		MODE_BANKED = 2'h1,
		MODE_INDEXED = 2'h2
	} addr_mode_t;
	typedef struct packed {
		logic [11:0] addr;
		logic rd;
	} mem_rd_t;
	typedef struct packed {
		logic [11:0] addr;
		logic [7:0] data;
		logic wr;
	} mem_wr_t;
endpackage

//--- rotl_unit.sv
// one-bit left rotate without carry
`timescale 1ns/1ps
module rotl_unit #(
	parameter int WIDTH = 8
) (
	input wire logic [WIDTH-1:0] operand, // byte read from memory
	output logic [WIDTH-1:0] result, // rotated byte
	output logic negative, // result top bit, bit WIDTH-1 (bit 7 at WIDTH 8)
	output logic zero // result is zero
);
	// a one-bit word has nothing to rotate, so refuse it at elaboration
	if (WIDTH < 2) begin : g_bad_width
		$error("rotl_unit needs WIDTH of at least 2");
	end
	// top bit wraps to bit 0, carry is never consulted
	assign result = {operand[WIDTH-2:0], operand[WIDTH-1]}; // RULE7
	assign negative = result[WIDTH-1];
	assign zero = (result == '0);
endmodule

//--- rotate_left_no_carry_exec.sv
// decode and execute of the rotate-left-no-carry byte instruction
`timescale 1ns/1ps
`include "rotate_params.svh"
// Function
// RULE1 - opcode 0100 01da ffffffff is recognised and the addressed byte is rotated left one place.
// RULE2 - with d at 0 the result goes to the working register and memory is left alone.
// RULE3 - with d at 1 the result is written back to the location it was read from.
// RULE4 - with a at 0 and extended set off the operand lies in the access bank, ignoring bank select.
// RULE5 - with a at 1 the bank select register plus the 8-bit address pick the memory bank.
// RULE6 - with a at 0, extended set on and address up to 95 indexed literal offset addressing is used.
// RULE7 - carry is untouched: bit 7 wraps to bit 0 and the other bits move up one.
// RULE8 - one word, one cycle: decode in Q1, read in Q2, rotate in Q3, write in Q4.
module rotate_left_no_carry_exec (
	input wire logic mclk, // 200 MHz core clock
	input wire logic rst_b, // asynchronous reset, active low
	input wire logic q1, // phase 1 strobe, one cycle
	input wire logic q2, // phase 2 strobe
	input wire logic q3, // phase 3 strobe
	input wire logic q4, // phase 4 strobe
	input wire logic [15:0] instr, // fetched program word
	input wire logic extEnable, // extended instruction set on
	input wire logic [3:0] bankSelect, // bank select register value
	input wire logic [11:0] indexedAddr, // indexed literal offset address
	input wire logic [7:0] memRdData, // data returned by memory in Q2
	output rotate_pkg::mem_rd_t memRd, // memory read request
	output rotate_pkg::mem_wr_t memWr, // memory write request
	output logic [7:0] wreg, // working register
	output logic flagN, // negative flag
	output logic flagZ, // zero flag
	output logic indexedReq, // indexed mode in use this cycle
	output logic busy // an instruction of this kind is in flight
);
	import rotate_pkg::*;

	// the opcode field and its match constant must agree in width
	if (`OPC_HI_POS - `OPC_LO_POS + 1 != `OPC_WIDTH) begin : g_bad_opcode
		$error("opcode field width does not match its match constant");
	end

	// one-hot phases of the instruction cycle
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_READ = 5'b00010,
		ST_ROT = 5'b00100,
		ST_WRITE = 5'b01000,
		ST_DONE = 5'b10000
	} phase_t;

	// phase tracking
	phase_t state;
	phase_t next_state;

	// instruction fields held for the whole cycle
	logic dest;
	logic next_dest;
	logic [11:0] addr;
	logic [11:0] next_addr;

	// operand and result bytes
	logic [7:0] opByte;
	logic [7:0] next_opByte;
	logic [7:0] resByte;
	logic [7:0] next_resByte;

	// next values of the registered outputs
	logic next_indexedReq;
	mem_rd_t next_memRd;
	mem_wr_t next_memWr;
	logic [7:0] next_wreg;
	logic next_flagN;
	logic next_flagZ;
	logic next_busy;

	// decode results, meaningful only while q1 stands
	logic hit;
	logic [7:0] fAddr;
	addr_mode_t mode;

	// rotator outputs, pure logic on the captured operand
	logic [7:0] rotRes;
	logic rotN;
	logic rotZ;

	// the rotate itself sits in a small unit of its own
	rotl_unit #(.WIDTH(8)) u_rot (
		.operand(opByte),
		.result(rotRes),
		.negative(rotN),
		.zero(rotZ)
	);

	// opcode match and address mode selection; the indexed address itself
	// is formed outside, only the mode is chosen here
	always_comb begin
		hit = (instr[`OPC_HI_POS:`OPC_LO_POS] == `OPC_RLNC); // RULE1
		fAddr = instr[7:0];
		if (instr[`ACC_POS]) begin
			mode = MODE_BANKED; // RULE5
		end else if (extEnable && (fAddr <= `INDEX_LIMIT)) begin
			mode = MODE_INDEXED; // RULE6
		end else begin
			mode = MODE_ACCESS; // RULE4
		end
	end

	// next-state logic; phases march one per strobe
	always_comb begin
		next_state = state;
		next_dest = dest;
		next_addr = addr;
		next_opByte = opByte;
		next_resByte = resByte;
		next_indexedReq = indexedReq;
		next_memRd = '0;
		next_memWr = '0;
		next_wreg = wreg;
		next_flagN = flagN;
		next_flagZ = flagZ;
		next_busy = busy;
		unique case (state)
			// done lasts one cycle so busy spans the write edge; a new q1 may start here
			ST_IDLE, ST_DONE: begin
				next_state = ST_IDLE;
				next_busy = 1'b0;
				next_indexedReq = 1'b0;
				if (q1 && hit) begin // RULE8
					next_state = ST_READ;
					next_busy = 1'b1;
					next_dest = instr[`DEST_POS];
					next_indexedReq = (mode == MODE_INDEXED);
					unique case (mode)
						MODE_BANKED: begin
							next_addr = {bankSelect, fAddr}; // RULE5
						end
						MODE_INDEXED: begin
							next_addr = indexedAddr; // RULE6
						end
						MODE_ACCESS: begin
							// low half maps to bank 0, high half to the special register bank
							if (fAddr >= `ACCESS_SPLIT) begin
								next_addr = {`ACCESS_HI_BANK, fAddr}; // RULE4
							end else begin
								next_addr = {`ACCESS_LO_BANK, fAddr}; // RULE4
							end
						end
						default: begin
							next_addr = `RESET_ADDR;
						end
					endcase
					// raise the read with the take edge so memory sees it for all of q2
					next_memRd.addr = next_addr;
					next_memRd.rd = 1'b1;
				end
			end

			ST_READ: begin
				// request stands until the q2 edge takes the byte; a late q2 stretches it
				if (q2) begin // RULE8
					next_opByte = memRdData;
					next_state = ST_ROT;
				end else begin
					next_memRd = memRd;
				end
			end

			ST_ROT: begin
				// operand has sat in opByte since the q2 edge
				if (q3) begin // RULE8
					next_resByte = rotRes; // RULE7
					next_flagN = rotN;
					next_flagZ = rotZ;
					next_state = ST_WRITE;
				end
			end

			ST_WRITE: begin
				// d picks memory or the working register, never both
				if (q4) begin // RULE8
					if (dest) begin
						next_memWr.addr = addr; // RULE3
						next_memWr.data = resByte;
						next_memWr.wr = 1'b1;
					end else begin
						next_wreg = resByte; // RULE2
					end
					next_state = ST_DONE;
				end
			end
		endcase
	end

	// state registers; every output leaves straight from here, so the
	// memory side never sees decode glitches
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			// every flop returns to its idle value at once
			state <= ST_IDLE;
			dest <= 1'b1;
			addr <= `RESET_ADDR;
			opByte <= `RESET_BYTE;
			resByte <= `RESET_BYTE;
			indexedReq <= 1'b0;
			memRd <= '0;
			memWr <= '0;
			wreg <= `RESET_WREG;
			flagN <= 1'b0;
			flagZ <= 1'b0;
			busy <= 1'b0;
		end else begin
			// registered copy of every next value
			state <= next_state;
			dest <= next_dest;
			addr <= next_addr;
			opByte <= next_opByte;
			resByte <= next_resByte;
			indexedReq <= next_indexedReq;
			memRd <= next_memRd;
			memWr <= next_memWr;
			wreg <= next_wreg;
			flagN <= next_flagN;
			flagZ <= next_flagZ;
			busy <= next_busy;
		end
	end
endmodule

//--- rlnc_sva.sv
// assertions for the rotate-left-no-carry executor
`timescale 1ns/1ps
module rlnc_sva (
	input wire logic mclk, // clock
	input wire logic rst_b, // reset, low
	input wire logic q1, // decode
	input wire logic q2, // read
	input wire logic q3, // rotate
	input wire logic q4, // write
	input wire logic [15:0] instr, // word
	input wire logic extEnable, // ext set
	input wire logic [3:0] bankSelect, // bank
	input wire logic [11:0] indexedAddr, // indexed
	input wire logic [7:0] memRdData, // read data
	input rotate_pkg::mem_rd_t memRd, // read
	input rotate_pkg::mem_wr_t memWr, // write
	input wire logic [7:0] wreg, // W
	input wire logic flagN, // N
	input wire logic flagZ, // Z
	input wire logic indexedReq, // indexed
	input wire logic busy // in flight
);
	import rotate_pkg::*;
	logic [11:0] ea;
	logic [7:0] op;
	logic d;
	logic ix;
	logic done; // the cycle after q4, in which a new q1 is already taken
	wire tk = q1 && instr[15:10] == 6'h11 && (!busy || done);
	wire nx = !instr[8] && extEnable && instr[7:0] <= 8'h5F;
	wire [7:0] r = {op[6:0], op[7]};
	// address, destination and mode expectations fixed at decode, since instr may move on afterwards; operand taken at q2
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ea <= 12'h000;
			op <= 8'h00;
			d <= 1'b0;
			ix <= 1'b0;
			done <= 1'b0;
		end else begin
			if (tk) begin
				d <= instr[9];
				ix <= nx;
				ea <= instr[8] ? {bankSelect, instr[7:0]} :
					nx ? indexedAddr : {{4{instr[7]}}, instr[7:0]};
			end
			if (q2 && busy) op <= memRdData;
			done <= q4 && busy;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	sequence sRun;
		tk ##1 q2 ##1 q3 ##1 q4;
	endsequence
	AST_TAKE: assert property (tk |=> busy && memRd.rd)
		else $error("decode missed");
	AST_REFUSE: assert property (q1 && !busy && instr[15:10] != 6'h11 |=> !busy)
		else $error("foreign opcode taken");
	AST_ADDR: assert property ($rose(busy) |-> memRd.addr == ea && indexedReq == ix)
		else $error("operand address wrong");
	AST_RDEND: assert property (q2 && busy |=> !memRd.rd)
		else $error("read held past q2");
	AST_FLAGS: assert property (q3 && busy |=> flagN == r[7] && flagZ == (r == 8'h00))
		else $error("flags wrong");
	AST_WB: assert property (memWr.wr |-> memWr.data == r && memWr.addr == ea && d)
		else $error("write back wrong");
	AST_WREG: assert property ($changed(wreg) |-> wreg == r && !d && $past(q4))
		else $error("working register wrong");
	AST_CYCLE: assert property (sRun |=> memWr.wr == d ##1 !busy)
		else $error("cycle timing wrong");
endmodule
bind rotate_left_no_carry_exec rlnc_sva chk (
	.mclk(mclk),
	.rst_b(rst_b),
	.q1(q1),
	.q2(q2),
	.q3(q3),
	.q4(q4),
	.instr(instr),
	.extEnable(extEnable),
	.bankSelect(bankSelect),
	.indexedAddr(indexedAddr),
	.memRdData(memRdData),
	.memRd(memRd),
	.memWr(memWr),
	.wreg(wreg),
	.flagN(flagN),
	.flagZ(flagZ),
	.indexedReq(indexedReq),
	.busy(busy)
);

//--- test_rotate_left_no_carry_exec.sv
// self-checking bench for the rotate-left-no-carry executor
`timescale 1ns/1ps
module test_rotate_left_no_carry_exec;
	import rotate_pkg::*;
	logic mclk = 1'b0, rst_b = 1'b0, q1 = 1'b0, q2 = 1'b0, q3 = 1'b0, q4 = 1'b0;
	logic extEnable = 1'b0;
	logic [15:0] instr = 16'h0000;
	logic [3:0] bankSelect = 4'h0;
	logic [11:0] indexedAddr = 12'h000;
	logic [7:0] memRdData = 8'h00, wreg;
	logic flagN, flagZ, indexedReq, busy;
	mem_rd_t memRd;
	mem_wr_t memWr;
	int n_mismatch = 0, checks = 0;
	rotate_left_no_carry_exec DUT (
		.mclk(mclk),
		.rst_b(rst_b),
		.q1(q1),
		.q2(q2),
		.q3(q3),
		.q4(q4),
		.instr(instr),
		.extEnable(extEnable),
		.bankSelect(bankSelect),
		.indexedAddr(indexedAddr),
		.memRdData(memRdData),
		.memRd(memRd),
		.memWr(memWr),
		.wreg(wreg),
		.flagN(flagN),
		.flagZ(flagZ),
		.indexedReq(indexedReq),
		.busy(busy)
	);
	always #2.5 mclk = ~mclk;
	task ck(input logic c);
		checks++;
		if (c !== 1'b1) begin
			n_mismatch++;
			$display("wrong value at %0t: output mismatch", $time);
		end
	endtask
	// one full instruction, strobes back to back, entered at a falling edge
	task automatic exec(input logic [15:0] w, input logic [7:0] v, input logic [11:0] a,
		input logic x);
		logic [7:0] r;
		r = {v[6:0], v[7]};
		q1 = 1'b1;
		instr = w;
		@(negedge mclk);
		ck(busy === 1'b1 && memRd.rd === 1'b1 && memRd.addr === a && indexedReq === x);
		q1 = 1'b0;
		q2 = 1'b1;
		memRdData = v;
		@(negedge mclk);
		ck(memRd.rd === 1'b0 && busy === 1'b1);
		q2 = 1'b0;
		q3 = 1'b1;
		memRdData = ~v; // read bus now driven with the inverted byte, so a late capture would show
		@(negedge mclk);
		ck(flagN === r[7] && flagZ === (r == 8'h00));
		q3 = 1'b0;
		q4 = 1'b1;
		@(negedge mclk);
		q4 = 1'b0;
		if (w[9]) ck(memWr.wr === 1'b1 && memWr.data === r && memWr.addr === a);
		else ck(memWr.wr === 1'b0 && wreg === r);
		@(negedge mclk);
		ck(busy === 1'b0 && memWr.wr === 1'b0);
	endtask
	task t_wreg;
		exec(16'h4420, 8'h81, 12'h020, 1'b0);
		$display("wreg test done");
	endtask
	task t_bank;
		bankSelect = 4'h5;
		exec(16'h47A3, 8'h80, 12'h5A3, 1'b0);
		$display("bank test done");
	endtask
	task t_idx;
		extEnable = 1'b1;
		indexedAddr = 12'h3C7;
		exec(16'h465F, 8'h7F, 12'h3C7, 1'b1);
		exec(16'h4460, 8'h40, 12'h060, 1'b0);
		exec(16'h4690, 8'h00, 12'hF90, 1'b0);
		$display("indexed test done");
	endtask
	task t_refuse;
		q1 = 1'b1;
		instr = 16'h4A20;
		@(negedge mclk);
		q1 = 1'b0;
		ck(busy === 1'b0 && memRd.rd === 1'b0);
		$display("refuse test done");
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (5) @(negedge mclk);
		rst_b = 1'b1;
		t_wreg;
		t_bank;
		t_idx;
		t_refuse;
		print_verdict;
	end
endmodule
